// File: verilog/rsmc_pkg.sv
// Constants, register map and enumerations of the retentive storage and
// mode controller.
// Assumes one 100 MHz clock and a transfer engine that moves the blocks.
package rsmc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int SAVE_MAX_MS = 5;
  localparam int SAVE_MAX_CYC = SAVE_MAX_MS * 1000 * CLK_MHZ;
  localparam logic [1:0] SETTLE_CYC = 2'h3;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_SAVE = 8'h0c;

  // Control: retentive bit-memory range enable, non-retentive at reset
  localparam int CTRL_RETAIN = 0;
  localparam logic CTRL_RETAIN_RST = 1'b0;

  // Command bits, each a one-shot request
  localparam int CMD_DOWNLOAD = 0;
  localparam int CMD_UPLOAD = 1;
  localparam int CMD_CART_COPY = 2;
  localparam int CMD_STOP = 3;
  localparam int CMD_RUN = 4;

  // Status bits, 3..6 sticky and cleared by writing one
  localparam int ST_RUN = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_LOST = 2;
  localparam int ST_CART_ERR = 3;
  localparam int ST_CART_REF = 4;
  localparam int ST_SAVE_TMO = 5;
  localparam int ST_CMD_REF = 6;

  // Save register fields
  localparam int SAVE_ADDR_LSB = 0;
  localparam int SAVE_ADDR_MSB = 15;
  localparam int SAVE_SIZE_LSB = 16;
  localparam int SAVE_SIZE_MSB = 17;
  localparam int SAVE_GO = 31;

  // Three-position selector encoding
  localparam logic [1:0] SW_STOP = 2'h0;
  localparam logic [1:0] SW_TERM = 2'h1;
  localparam logic [1:0] SW_RUN = 2'h2;

  // Retentive bit-memory bytes saved on supply loss
  localparam logic [7:0] FIRST_RETENTIVE_BIT_BYTE = 8'h00;
  localparam logic [7:0] LAST_RETENTIVE_BIT_BYTE = 8'h0d;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [4:0] {
    OP_SKIP, OP_END, OP_LOAD_PROG, OP_LOAD_SYS, OP_LOAD_DATA, OP_CLEAR_RAM,
    OP_SAVE_MRET, OP_PROG_TO_NV, OP_SYS_TO_NV, OP_DATA_TO_NV, OP_CART_CMP,
    OP_CART_TO_RAM, OP_CART_WR_PROG, OP_CART_WR_DATA, OP_CART_WR_SYS,
    OP_CART_WR_FORCE, OP_UP_SYS_RAM, OP_UP_PROG_NV, OP_UP_DATA_NV,
    OP_VAR_SAVE
  } rsmc_op_t;

  typedef enum logic [2:0] {
    SQ_BOOT, SQ_CART_BOOT, SQ_PWRFAIL, SQ_DOWNLOAD, SQ_UPLOAD, SQ_CART_WR,
    SQ_VSAVE
  } rsmc_seq_t;

endpackage

// File: verilog/rsmc_top.sv
// Retentive storage, restore and operating mode controller.
// Assumes a transfer engine on ref_clk that carries out each operation
// code and answers with op_done; pins pass a two-flop synchroniser.
//
// Local design decisions: strobed register access and the register offsets.

// Notes on behaviour
// - Save retentive bit bytes on supply loss
// - Retentive range disabled after reset
// - Power on reloads program and system blocks
// - Intact volatile memory keeps retentive areas
// - Power on reloads variable memory from data
// - Lost memory: clear, flag first scan, reload
// - Download commit writes program, data, system
// - Upload: system from RAM, rest nonvolatile
// - Cartridge gets program, data, system, forced
// - Cartridge copy only stopped with cartridge present
// - Cartridge restore only during power up
// - Restore: clear if different, copy, store
// - Reject higher-model or blank cartridges
// - Stop halts program and permits download
// - Front indicator shows current mode
// - Selector stop halts, run starts, terminal keeps
// - Power up mode follows selector position
// - Host mode commands ignored at selector stop
// - Stop instruction enters stop mode
// - Variable save over five milliseconds flagged, not aborted
// - Variable save overwrites nonvolatile, not cartridge
module rsmc_top #(
  parameter int MODEL_W = 4,
  parameter logic [MODEL_W-1:0] OWN_MODEL = 4'h2,
  parameter int SAVE_LIMIT_CYC = rsmc_pkg::SAVE_MAX_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Pins
  input wire logic [1:0] mode_sw,
  input wire logic power_lost,
  input wire logic cart_present,
  input wire logic cart_blank,
  input wire logic [MODEL_W-1:0] cart_model,
  // Program execution side
  input wire logic scan_end,
  input wire logic stop_instr,
  input wire logic ram_intact,
  output logic prog_exec,
  output logic run_led,
  output logic retained_data_lost_flag,
  output logic scan_hold,
  // Transfer engine
  output logic op_start,
  output rsmc_pkg::rsmc_op_t op_code,
  output logic [15:0] save_addr,
  output logic [1:0] save_size,
  input wire logic op_done,
  input wire logic op_differs,
  output logic busy
);

  // ****************************************
  // Reset and pin synchronisers
  // ****************************************
  localparam int PIN_W = MODEL_W + 5;
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [PIN_W-1:0] pin_m_r, pin_s_r;
  logic [1:0] sw_s, sw_prev_r;
  logic pl_s, cp_s, cb_s;
  logic [MODEL_W-1:0] cm_s;

  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  assign rst_n = rst_sync_r[1];

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      pin_m_r <= '0;
      pin_s_r <= '0;
    end
    else
    begin
      pin_m_r <= {mode_sw, power_lost, cart_present, cart_blank, cart_model};
      pin_s_r <= pin_m_r;
    end
  assign {sw_s, pl_s, cp_s, cb_s, cm_s} = pin_s_r;

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      sw_prev_r <= rsmc_pkg::SW_TERM;
    else
      sw_prev_r <= sw_s;

  // ****************************************
  // Sequence table
  // ****************************************
  function automatic rsmc_pkg::rsmc_op_t step_op(
    input rsmc_pkg::rsmc_seq_t sq, input logic [2:0] i,
    input logic ram_ok, input logic differs);
    rsmc_pkg::rsmc_op_t op;
    op = rsmc_pkg::OP_END;
    case (sq)
      rsmc_pkg::SQ_BOOT:
        case (i)
          3'h0: op = rsmc_pkg::OP_LOAD_PROG;
          3'h1: op = rsmc_pkg::OP_LOAD_SYS;
          3'h2: op = ram_ok ? rsmc_pkg::OP_SKIP : rsmc_pkg::OP_CLEAR_RAM;
          3'h3: op = rsmc_pkg::OP_LOAD_DATA;
          default: op = rsmc_pkg::OP_END;
        endcase
      rsmc_pkg::SQ_CART_BOOT:
        case (i)
          3'h0: op = rsmc_pkg::OP_CART_CMP;
          3'h1: op = differs ? rsmc_pkg::OP_CLEAR_RAM : rsmc_pkg::OP_SKIP;
          3'h2: op = rsmc_pkg::OP_CART_TO_RAM;
          3'h3: op = rsmc_pkg::OP_PROG_TO_NV;
          3'h4: op = rsmc_pkg::OP_SYS_TO_NV;
          3'h5: op = rsmc_pkg::OP_DATA_TO_NV;
          default: op = rsmc_pkg::OP_END;
        endcase
      rsmc_pkg::SQ_PWRFAIL:
        op = (i == 3'h0) ? rsmc_pkg::OP_SAVE_MRET : rsmc_pkg::OP_END;
      rsmc_pkg::SQ_DOWNLOAD:
        case (i)
          3'h0: op = rsmc_pkg::OP_PROG_TO_NV;
          3'h1: op = rsmc_pkg::OP_DATA_TO_NV;
          3'h2: op = rsmc_pkg::OP_SYS_TO_NV;
          default: op = rsmc_pkg::OP_END;
        endcase
      rsmc_pkg::SQ_UPLOAD:
        case (i)
          3'h0: op = rsmc_pkg::OP_UP_SYS_RAM;
          3'h1: op = rsmc_pkg::OP_UP_PROG_NV;
          3'h2: op = rsmc_pkg::OP_UP_DATA_NV;
          default: op = rsmc_pkg::OP_END;
        endcase
      rsmc_pkg::SQ_CART_WR:
        case (i)
          3'h0: op = rsmc_pkg::OP_CART_WR_PROG;
          3'h1: op = rsmc_pkg::OP_CART_WR_DATA;
          3'h2: op = rsmc_pkg::OP_CART_WR_SYS;
          3'h3: op = rsmc_pkg::OP_CART_WR_FORCE;
          default: op = rsmc_pkg::OP_END;
        endcase
      rsmc_pkg::SQ_VSAVE:
        op = (i == 3'h0) ? rsmc_pkg::OP_VAR_SAVE : rsmc_pkg::OP_END;
      default: op = rsmc_pkg::OP_END;
    endcase
    return op;
  endfunction

  // ****************************************
  // Register decode
  // ****************************************
  logic retain_en_r, mode_run_r, booted_r, lost_r;
  logic cart_err_r, cart_ref_r, save_tmo_r, cmd_ref_r;
  logic save_go_r, differs_r;
  logic [15:0] save_addr_r;
  logic [1:0] save_size_r;
  logic [31:0] rdata_r;
  logic wr_ctrl, wr_cmd, wr_stat, wr_save;
  logic cmd_dl, cmd_up, cmd_cw, cmd_stop, cmd_run;

  assign wr_ctrl = reg_wr && (reg_addr == rsmc_pkg::REG_CTRL);
  assign wr_cmd = reg_wr && (reg_addr == rsmc_pkg::REG_CMD);
  assign wr_stat = reg_wr && (reg_addr == rsmc_pkg::REG_STATUS);
  assign wr_save = reg_wr && (reg_addr == rsmc_pkg::REG_SAVE);
  assign cmd_dl = wr_cmd && reg_wdata[rsmc_pkg::CMD_DOWNLOAD];
  assign cmd_up = wr_cmd && reg_wdata[rsmc_pkg::CMD_UPLOAD];
  assign cmd_cw = wr_cmd && reg_wdata[rsmc_pkg::CMD_CART_COPY];
  assign cmd_stop = wr_cmd && reg_wdata[rsmc_pkg::CMD_STOP];
  assign cmd_run = wr_cmd && reg_wdata[rsmc_pkg::CMD_RUN];

  // ****************************************
  // Sequencer
  // ****************************************
  typedef enum logic [2:0] {
    ST_SETTLE, ST_IDLE, ST_ISSUE, ST_WAIT, ST_HALT
  } rsmc_state_t;
  rsmc_state_t state_r;
  rsmc_pkg::rsmc_seq_t seq_r;
  rsmc_pkg::rsmc_op_t cur_op;
  logic [2:0] idx_r;
  logic [1:0] settle_r;
  logic [19:0] save_cnt_r;
  logic op_start_r, seq_end, cart_ok, dl_ok, cw_ok;
  rsmc_pkg::rsmc_op_t op_code_r;

  assign cur_op = step_op(seq_r, idx_r, ram_intact, differs_r);
  assign seq_end = (state_r == ST_ISSUE) && (cur_op == rsmc_pkg::OP_END);
  assign cart_ok = !cb_s && (cm_s <= OWN_MODEL);
  assign dl_ok = !mode_run_r;
  assign cw_ok = !mode_run_r && cp_s;

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      state_r <= ST_SETTLE;
      seq_r <= rsmc_pkg::SQ_BOOT;
      idx_r <= 3'h0;
      settle_r <= 2'h0;
    end
    else
      case (state_r)
        ST_SETTLE:
          if (settle_r == rsmc_pkg::SETTLE_CYC)
          begin
            state_r <= ST_ISSUE;
            idx_r <= 3'h0;
            // Cartridge restore is only chosen here, at power up
            seq_r <= (cp_s && cart_ok) ? rsmc_pkg::SQ_CART_BOOT
                                       : rsmc_pkg::SQ_BOOT;
          end
          else
            settle_r <= settle_r + 2'h1;
        ST_IDLE:
        begin
          idx_r <= 3'h0;
          if (pl_s)
          begin
            state_r <= retain_en_r ? ST_ISSUE : ST_HALT;
            seq_r <= rsmc_pkg::SQ_PWRFAIL;
          end
          else if (save_go_r && scan_end)
          begin
            state_r <= ST_ISSUE;
            seq_r <= rsmc_pkg::SQ_VSAVE;
          end
          else if (cmd_dl && dl_ok)
          begin
            state_r <= ST_ISSUE;
            seq_r <= rsmc_pkg::SQ_DOWNLOAD;
          end
          else if (cmd_up)
          begin
            state_r <= ST_ISSUE;
            seq_r <= rsmc_pkg::SQ_UPLOAD;
          end
          else if (cmd_cw && cw_ok)
          begin
            state_r <= ST_ISSUE;
            seq_r <= rsmc_pkg::SQ_CART_WR;
          end
        end
        ST_ISSUE:
          if (cur_op == rsmc_pkg::OP_END)
            state_r <= (seq_r == rsmc_pkg::SQ_PWRFAIL) ? ST_HALT : ST_IDLE;
          else if (cur_op == rsmc_pkg::OP_SKIP)
            idx_r <= idx_r + 3'h1;
          else
            state_r <= ST_WAIT;
        ST_WAIT:
          if (op_done)
          begin
            idx_r <= idx_r + 3'h1;
            state_r <= ST_ISSUE;
          end
        ST_HALT:
          state_r <= ST_HALT;
        default:
          state_r <= ST_HALT;
      endcase

  // Operation code and start pulse toward the transfer engine
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      op_start_r <= 1'b0;
      op_code_r <= rsmc_pkg::OP_END;
    end
    else
    begin
      op_start_r <= (state_r == ST_ISSUE) && (cur_op != rsmc_pkg::OP_END)
                    && (cur_op != rsmc_pkg::OP_SKIP);
      if ((state_r == ST_ISSUE) && (cur_op != rsmc_pkg::OP_SKIP))
        op_code_r <= cur_op;
    end

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      differs_r <= 1'b0;
    else if ((state_r == ST_WAIT) && op_done
             && (op_code_r == rsmc_pkg::OP_CART_CMP))
      differs_r <= op_differs;

  // Save duration watchdog
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      save_cnt_r <= 20'h0;
    else if ((state_r == ST_WAIT) && (seq_r == rsmc_pkg::SQ_VSAVE))
      save_cnt_r <= save_cnt_r + 20'h1;
    else
      save_cnt_r <= 20'h0;

  // ****************************************
  // Operating mode
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      mode_run_r <= 1'b0;
      booted_r <= 1'b0;
    end
    else if ((state_r == ST_HALT) || pl_s)
      mode_run_r <= 1'b0;
    else if (!booted_r)
    begin
      if (seq_end)
      begin
        booted_r <= 1'b1;
        mode_run_r <= (sw_s == rsmc_pkg::SW_RUN);
      end
    end
    else if (stop_instr)
      mode_run_r <= 1'b0;
    else if ((sw_s != sw_prev_r) && (sw_s == rsmc_pkg::SW_STOP))
      mode_run_r <= 1'b0;
    else if ((sw_s != sw_prev_r) && (sw_s == rsmc_pkg::SW_RUN))
      mode_run_r <= 1'b1;
    else if (sw_s != rsmc_pkg::SW_STOP)
    begin
      if (cmd_stop)
        mode_run_r <= 1'b0;
      else if (cmd_run)
        mode_run_r <= 1'b1;
    end

  // ****************************************
  // Flags and software registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      lost_r <= 1'b0;
    else if ((state_r == ST_ISSUE) && (seq_r == rsmc_pkg::SQ_BOOT)
             && (cur_op == rsmc_pkg::OP_CLEAR_RAM))
      lost_r <= 1'b1;
    else if (booted_r && mode_run_r && scan_end)
      lost_r <= 1'b0;

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      cart_err_r <= 1'b0;
      cart_ref_r <= 1'b0;
      save_tmo_r <= 1'b0;
      cmd_ref_r <= 1'b0;
    end
    else
    begin
      // Set wins over a write-one clear in the same cycle
      if ((state_r == ST_SETTLE) && (settle_r == rsmc_pkg::SETTLE_CYC)
          && cp_s && !cart_ok)
        cart_err_r <= 1'b1;
      else if (wr_stat && reg_wdata[rsmc_pkg::ST_CART_ERR])
        cart_err_r <= 1'b0;
      if (cmd_cw && !cw_ok)
        cart_ref_r <= 1'b1;
      else if (wr_stat && reg_wdata[rsmc_pkg::ST_CART_REF])
        cart_ref_r <= 1'b0;
      if (save_cnt_r == 20'(SAVE_LIMIT_CYC))
        save_tmo_r <= 1'b1;
      else if (wr_stat && reg_wdata[rsmc_pkg::ST_SAVE_TMO])
        save_tmo_r <= 1'b0;
      if ((wr_cmd && (state_r != ST_IDLE)) || (cmd_dl && !dl_ok))
        cmd_ref_r <= 1'b1;
      else if (wr_stat && reg_wdata[rsmc_pkg::ST_CMD_REF])
        cmd_ref_r <= 1'b0;
    end

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      retain_en_r <= rsmc_pkg::CTRL_RETAIN_RST;
    else if (wr_ctrl)
      retain_en_r <= reg_wdata[rsmc_pkg::CTRL_RETAIN];

  // Address and size are frozen while a save is pending or running
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      save_go_r <= 1'b0;
      save_addr_r <= 16'h0;
      save_size_r <= 2'h0;
    end
    else if (seq_end && (seq_r == rsmc_pkg::SQ_VSAVE))
      save_go_r <= 1'b0;
    else if (wr_save && !save_go_r)
    begin
      save_go_r <= reg_wdata[rsmc_pkg::SAVE_GO];
      save_addr_r <= reg_wdata[rsmc_pkg::SAVE_ADDR_MSB:
                               rsmc_pkg::SAVE_ADDR_LSB];
      save_size_r <= reg_wdata[rsmc_pkg::SAVE_SIZE_MSB:
                               rsmc_pkg::SAVE_SIZE_LSB];
    end

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      rdata_r <= 32'h0;
    else
    begin
      rdata_r <= 32'h0;
      if (reg_rd)
        case (reg_addr)
          rsmc_pkg::REG_CTRL:
            rdata_r[rsmc_pkg::CTRL_RETAIN] <= retain_en_r;
          rsmc_pkg::REG_STATUS:
            rdata_r[rsmc_pkg::ST_CMD_REF:rsmc_pkg::ST_RUN] <=
              {cmd_ref_r, save_tmo_r, cart_ref_r, cart_err_r, lost_r,
               busy, mode_run_r};
          rsmc_pkg::REG_SAVE:
            rdata_r <= {save_go_r, 13'h0, save_size_r, save_addr_r};
          default:
            rdata_r <= 32'h0;
        endcase
    end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = rdata_r;
  assign busy = (state_r != ST_IDLE);
  assign run_led = mode_run_r;
  assign prog_exec = mode_run_r && booted_r;
  assign retained_data_lost_flag = lost_r;
  assign scan_hold = (state_r != ST_IDLE) && (seq_r == rsmc_pkg::SQ_VSAVE);
  assign op_start = op_start_r;
  assign op_code = op_code_r;
  assign save_addr = save_addr_r;
  assign save_size = save_size_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_retain_reset: assert property (!$past(rst_n) |-> !retain_en_r)
    else $error("retentive range enabled after reset");
  a_pwrfail_save: assert property (
    (state_r == ST_IDLE) && pl_s && retain_en_r |->
      ##2 op_start && (op_code == rsmc_pkg::OP_SAVE_MRET))
    else $error("supply loss did not start retentive save");
  a_pwrfail_nosave: assert property (
    (state_r == ST_IDLE) && pl_s && !retain_en_r |=>
      (state_r == ST_HALT) && !op_start)
    else $error("save issued with retentive range disabled");
  a_cart_refuse: assert property (
    (state_r == ST_IDLE) && cmd_cw && mode_run_r && !pl_s |=>
      cart_ref_r && (state_r == ST_IDLE))
    else $error("cartridge copy accepted in run mode");
  a_restore_boot: assert property (
    op_start && (op_code == rsmc_pkg::OP_CART_TO_RAM) |-> !booted_r)
    else $error("cartridge restore while powered");
  a_stop_instr: assert property (
    booted_r && stop_instr |=> !mode_run_r && !prog_exec)
    else $error("stop instruction did not stop");
  a_host_ignored: assert property (
    booted_r && cmd_run && !mode_run_r && (sw_s == rsmc_pkg::SW_STOP)
    && !stop_instr |=> !mode_run_r)
    else $error("host run honoured at selector stop");
  a_busy_writes: assert property (
    op_start |-> busy ##1 (busy throughout (!op_done [*1])))
    else $error("not busy during an operation");
  a_lost_scan: assert property (
    lost_r && booted_r && mode_run_r && scan_end |=>
      !retained_data_lost_flag)
    else $error("data-lost flag held past first scan");
  a_boot_mode: assert property (
    !booted_r && seq_end && !pl_s |=>
      (run_led == ($past(sw_s) == rsmc_pkg::SW_RUN)))
    else $error("power-up mode does not follow selector");

  c_boot_done: cover property (!booted_r ##1 booted_r);
  c_download: cover property (
    op_start && (op_code == rsmc_pkg::OP_SYS_TO_NV) && booted_r);
  c_cart_write: cover property (
    op_start && (op_code == rsmc_pkg::OP_CART_WR_FORCE));
  c_var_save: cover property (op_start && (op_code == rsmc_pkg::OP_VAR_SAVE));

endmodule

// File: verification/rsmc_engine_model.sv
// Stand-in for the transfer engine: ends each op after one or four cycles.
// Assumes op_start pulses one cycle on the controller clock.
module rsmc_engine_model (
  // Clock
  input wire logic clk,
  // Engine handshake
  input wire logic op_start,
  input wire logic differs,
  output logic op_done,
  output logic op_differs
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_r = 3'h0;
  logic slow_r = 1'b0;
  // Compare result means nothing away from op_done
  assign op_differs = op_done ? differs : ~differs;
  always @(posedge clk)
  begin
    op_done <= (cnt_r == 3'h1);
    if (cnt_r != 3'h0)
      cnt_r <= cnt_r - 3'h1;
    else if (op_start)
    begin
      cnt_r <= slow_r ? 3'h4 : 3'h1;
      slow_r <= ~slow_r;
    end
  end
endmodule

// File: verification/rsmc_top_tb.sv
// Self-checking bench of the storage and mode controller.
// Assumes the engine model beside it and a 100 MHz clock.
module rsmc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, d;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [1:0] mode_sw = rsmc_pkg::SW_RUN;
  logic power_lost = 1'b0, cart_present = 1'b0, cart_blank = 1'b0;
  logic [3:0] cart_model = 4'h0;
  logic scan_end = 1'b0, stop_instr = 1'b0, ram_intact = 1'b0;
  logic differs = 1'b0;
  logic prog_exec, run_led, lost, scan_hold, op_start, op_done;
  logic op_differs, busy;
  logic [15:0] save_addr;
  logic [1:0] save_size;
  rsmc_pkg::rsmc_op_t op_code;
  rsmc_pkg::rsmc_op_t seen[$];
  int mismatches = 0, n_compared = 0;

  // Save limit lies between the model's fast and slow save
  rsmc_top #(.SAVE_LIMIT_CYC(4)) dut_u (.ref_clk(ref_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_sw(mode_sw),
    .power_lost(power_lost), .cart_present(cart_present),
    .cart_blank(cart_blank), .cart_model(cart_model), .scan_end(scan_end),
    .stop_instr(stop_instr), .ram_intact(ram_intact),
    .prog_exec(prog_exec), .run_led(run_led),
    .retained_data_lost_flag(lost), .scan_hold(scan_hold),
    .op_start(op_start), .op_code(op_code), .save_addr(save_addr),
    .save_size(save_size), .op_done(op_done), .op_differs(op_differs),
    .busy(busy));
  rsmc_engine_model eng_u (.clk(ref_clk), .op_start(op_start),
    .differs(differs), .op_done(op_done), .op_differs(op_differs));

  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
    if (op_start === 1'b1)
      seen.push_back(op_code);

  // ****************************************
  // Bus, wait and compare tasks
  // ****************************************
  task automatic check(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Zero waits for idle, otherwise for that many engine ops
  task automatic settle(input int n);
    int k = 0;
    repeat (3) @(posedge ref_clk);
    while (n ? seen.size() < n : busy !== 1'b0)
    begin
      @(posedge ref_clk) #1;
      k++;
      if (k > 3000)
      begin
        check("wait", 0, 1);
        end_sim();
      end
    end
  endtask
  task automatic chk_ops(input rsmc_pkg::rsmc_op_t e[$]);
    check("op_count", seen.size(), e.size());
    foreach (e[i])
      if (i < seen.size())
        check("op_code", seen[i], e[i]);
    seen.delete();
  endtask
  task automatic led_is(input logic v);
    repeat (8) @(posedge ref_clk);
    #1 check("run_led", run_led, v);
    check("prog_exec", prog_exec, v);
  endtask
  task automatic pulse(input int w);
    @(posedge ref_clk);
    if (w)
      stop_instr <= 1'b1;
    else
      scan_end <= 1'b1;
    @(posedge ref_clk);
    stop_instr <= 1'b0;
    scan_end <= 1'b0;
  endtask
  task automatic pins(input logic [1:0] sw, input logic cp);
    @(posedge ref_clk);
    mode_sw <= sw;
    cart_present <= cp;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic reboot(input logic ri, cp, input logic [3:0] m);
    @(posedge ref_clk);
    nrst <= 1'b0;
    ram_intact <= ri;
    cart_present <= cp;
    cart_model <= m;
    power_lost <= 1'b0;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    seen.delete();
    settle(0);
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    reboot(1'b0, 1'b0, 4'h0);
    chk_ops('{rsmc_pkg::OP_LOAD_PROG, rsmc_pkg::OP_LOAD_SYS,
      rsmc_pkg::OP_CLEAR_RAM, rsmc_pkg::OP_LOAD_DATA});
    check("lost", lost, 1);
    led_is(1'b1);
    rd(rsmc_pkg::REG_CTRL);
    check("ctrl", d, 0);
    pulse(0);
    #1 check("lost", lost, 0);
    wr(rsmc_pkg::REG_CMD, 32'h4);
    wr(rsmc_pkg::REG_CMD, 32'h1);
    rd(rsmc_pkg::REG_STATUS);
    check("refusals", d[6:0], 7'h51);
    check("no_ops", seen.size(), 0);
    wr(rsmc_pkg::REG_STATUS, 32'h78);
    wr(rsmc_pkg::REG_CMD, 32'h8);
    led_is(1'b0);
    wr(rsmc_pkg::REG_CMD, 32'h10);
    led_is(1'b1);
    pulse(1);
    led_is(1'b0);
    pins(rsmc_pkg::SW_STOP, 1'b0);
    wr(rsmc_pkg::REG_CMD, 32'h10);
    led_is(1'b0);
    wr(rsmc_pkg::REG_CMD, 32'h1);
    wr(rsmc_pkg::REG_CMD, 32'h2);
    settle(0);
    chk_ops('{rsmc_pkg::OP_PROG_TO_NV, rsmc_pkg::OP_DATA_TO_NV,
      rsmc_pkg::OP_SYS_TO_NV});
    rd(rsmc_pkg::REG_STATUS);
    check("busy_ref", d[6], 1);
    wr(rsmc_pkg::REG_CMD, 32'h2);
    settle(0);
    chk_ops('{rsmc_pkg::OP_UP_SYS_RAM, rsmc_pkg::OP_UP_PROG_NV,
      rsmc_pkg::OP_UP_DATA_NV});
    pins(rsmc_pkg::SW_STOP, 1'b1);
    wr(rsmc_pkg::REG_CMD, 32'h4);
    settle(0);
    chk_ops('{rsmc_pkg::OP_CART_WR_PROG, rsmc_pkg::OP_CART_WR_DATA,
      rsmc_pkg::OP_CART_WR_SYS, rsmc_pkg::OP_CART_WR_FORCE});
    pins(rsmc_pkg::SW_TERM, 1'b1);
    led_is(1'b0);
    wr(rsmc_pkg::REG_CMD, 32'h10);
    led_is(1'b1);
    pins(rsmc_pkg::SW_STOP, 1'b1);
    led_is(1'b0);
    pins(rsmc_pkg::SW_RUN, 1'b1);
    led_is(1'b1);
    wr(rsmc_pkg::REG_SAVE, 32'h8001_0123);
    pulse(0);
    #1 check("scan_hold", scan_hold, 1);
    settle(0);
    chk_ops('{rsmc_pkg::OP_VAR_SAVE});
    check("save_loc", {save_size, save_addr}, 18'h10123);
    rd(rsmc_pkg::REG_SAVE);
    check("save_go", d[31], 0);
    rd(rsmc_pkg::REG_STATUS);
    check("save_tmo", d[5], 0);
    wr(rsmc_pkg::REG_SAVE, 32'h8002_0200);
    pulse(0);
    settle(0);
    chk_ops('{rsmc_pkg::OP_VAR_SAVE});
    rd(rsmc_pkg::REG_STATUS);
    check("save_tmo", d[5], 1);
    wr(rsmc_pkg::REG_CTRL, 32'h1);
    @(posedge ref_clk);
    power_lost <= 1'b1;
    settle(1);
    chk_ops('{rsmc_pkg::OP_SAVE_MRET});
    led_is(1'b0);
    pins(rsmc_pkg::SW_TERM, 1'b1);
    reboot(1'b1, 1'b1, 4'h3);
    chk_ops('{rsmc_pkg::OP_LOAD_PROG, rsmc_pkg::OP_LOAD_SYS,
      rsmc_pkg::OP_LOAD_DATA});
    check("lost", lost, 0);
    led_is(1'b0);
    rd(rsmc_pkg::REG_STATUS);
    check("cart_err", d[3], 1);
    differs <= 1'b1;
    reboot(1'b1, 1'b1, 4'h1);
    chk_ops('{rsmc_pkg::OP_CART_CMP, rsmc_pkg::OP_CLEAR_RAM,
      rsmc_pkg::OP_CART_TO_RAM, rsmc_pkg::OP_PROG_TO_NV,
      rsmc_pkg::OP_SYS_TO_NV, rsmc_pkg::OP_DATA_TO_NV});
    cart_blank <= 1'b1;
    reboot(1'b1, 1'b1, 4'h1);
    chk_ops('{rsmc_pkg::OP_LOAD_PROG, rsmc_pkg::OP_LOAD_SYS,
      rsmc_pkg::OP_LOAD_DATA});
    rd(rsmc_pkg::REG_STATUS);
    check("blank_err", d[3], 1);
    @(posedge ref_clk);
    power_lost <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1 check("no_save", seen.size(), 0);
    check("halt_busy", busy, 1);
    end_sim();
  end
endmodule
